/* sac_analog_model.sv */
// Purpose: Behavioural comparator, resistor string and sample-and-hold facing the sequencer
// Assumes: Channel levels are given by the bench as 8-bit codes
// Notes:   An unpowered comparator toggles its output, so a stale answer is never trusted
`timescale 1ns/1ps
module sac_analog_model (
  input  wire logic        clk,
  input  wire logic [63:0] levels,
  input  wire logic [2:0]  analogSelect,
  input  wire logic        sampleEn,
  input  wire logic [7:0]  tapSelect,
  input  wire logic        compPowerDown,
  output logic             compHigh
);
  // ----------------------------------------------------------------
  // Sample-and-hold and comparator
  // ----------------------------------------------------------------
  logic [7:0] held;
  logic       idleToggle = 1'b0;

  // Track the routed input only while sampling, then freeze it
  always @(posedge clk) begin
    if (sampleEn) begin
      held <= levels[{analogSelect, 3'b000} +: 8];
    end
    idleToggle <= ~idleToggle;
  end

  // Tap code k stands for level k, so a direct compare yields the binary search
  always_comb begin
    compHigh = compPowerDown ? idleToggle : (held >= tapSelect);
  end
endmodule // sac_analog_model

/* sac_edge_detect.sv */
// Purpose: Valid-edge detector on the shared trigger pin
// Assumes: Pin is synchronous to clk
// Notes:   First sample after reset only arms the detector
`timescale 1ns/1ps
module sac_edge_detect (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       triggerPin,
  input  wire logic [1:0] edgeMode,
  output logic            edgePulse
);

  sac_pkg::sac_edge_s st_r;
  sac_pkg::sac_edge_s st_nxt;
  logic               rise;
  logic               fall;

  assign rise = st_r.armed && triggerPin && !st_r.prevPin;
  assign fall = st_r.armed && !triggerPin && st_r.prevPin;

  always_comb begin
    st_nxt         = st_r;
    st_nxt.armed   = 1'b1;
    st_nxt.prevPin = triggerPin;
    case (sac_pkg::sac_edge_e'(edgeMode))
      sac_pkg::SAC_EDGE_FALL: st_nxt.pulse = fall;
      sac_pkg::SAC_EDGE_RISE: st_nxt.pulse = rise;
      sac_pkg::SAC_EDGE_BOTH: st_nxt.pulse = rise || fall;
      default:                st_nxt.pulse = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign edgePulse = st_r.pulse;

endmodule // sac_edge_detect

/* sac_map.svh */
// Purpose: Addresses, field positions, reset values and timing counts of the converter control
// Assumes: Byte-wide CPU register port, 20-bit address space
// Notes:   Definitions only; included by the sequencer
//
// Contract
// - Channel code and operating mode choose the analog input routed to sampling.
// - Inputs are sampled one at a time and held for the whole conversion.
// - Tap selector follows the approximation value, one of 256 equal steps.
// - Approximation resolves one bit per comparison, most significant bit first.
// - After the last bit, the approximation is copied into the result register.
// - Result register content after reset is undefined and not relied upon.
// - Trigger pin edge detector yields external interrupt and trigger; polarity selectable.
// - Mode register: 8 bits at 0FF68H, byte and single-bit writable, readable.
// - Mode bit 0: zero scans several channels, one converts a single channel.
// - Mode bits 1 to 3 hold channel code; single mode converts input n.
// - Scan mode with code n converts channels 0 through n in order.
// - Mode bit 5 picks scanning without or with delay control.
// - With trigger enable and run set, each valid edge restarts the sequence; the code ignores an edge that arrives in the idle state.
// - With trigger enable clear, trigger pin has no effect on conversions.
// - Setting run bit 7 starts conversion operation.
// - Clearing run aborts at once; result unchanged, no completion interrupt.
// - While run is clear, the comparator power-down control is asserted.
// - Reset clears the mode register to 00H.
// - Halt with run set stops conversion but keeps the comparator powered.
// - Conversions repeat until run clears; any mode write reinitialises the operation.
// - Completion interrupt is raised when a result enters the result register.
// - Mode bit 4 selects speed; fast takes 120 clocks, slow takes longer.
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define SAC_ADDR_MODE      20'h0_FF68
`define SAC_ADDR_RESULT    20'h0_FF6A
`define SAC_MODE_RESET     8'h00

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define SAC_BIT_SINGLE     0
`define SAC_CODE_LSB       1
`define SAC_CODE_MSB       3
`define SAC_BIT_FAST       4
`define SAC_BIT_DELAY      5
`define SAC_BIT_TRIG       6
`define SAC_BIT_RUN        7

// ----------------------------------------------------------------
// Timing counts in system clocks
// ----------------------------------------------------------------
`define SAC_FAST_CONV_CLK  16'h0078
`define SAC_FAST_BIT_CLK   16'h000C
`define SAC_SLOW_CONV_CLK  16'h00F2
`define SAC_SLOW_BIT_CLK   16'h0018
`define SAC_SCAN_DELAY_CLK 16'h0010

`endif

/* sac_pkg.sv */
// Purpose: Types shared by the converter control modules
// Assumes: Nothing beyond the map header
// Notes:   State codes are one-hot
package sac_pkg;

  typedef enum logic [4:0] {
    SAC_ST_IDLE    = 5'b0_0001,
    SAC_ST_WAIT    = 5'b0_0010,
    SAC_ST_SAMPLE  = 5'b0_0100,
    SAC_ST_COMPARE = 5'b0_1000,
    SAC_ST_DELAY   = 5'b1_0000
  } sac_state_e;

  typedef enum logic [1:0] {
    SAC_EDGE_FALL = 2'h0,
    SAC_EDGE_RISE = 2'h1,
    SAC_EDGE_BOTH = 2'h2,
    SAC_EDGE_NONE = 2'h3
  } sac_edge_e;

  typedef struct packed {
    logic armed;
    logic prevPin;
    logic pulse;
  } sac_edge_s;

  typedef struct packed {
    logic [7:0]  mode;
    sac_state_e  state;
    logic [7:0]  approx;
    logic [2:0]  bitIdx;
    logic [15:0] cnt;
    logic [2:0]  chan;
    logic [7:0]  result;
    logic        doneIrq;
    logic [7:0]  rdData;
  } sac_seq_s;

endpackage

/* sac_sequencer.sv */
// Purpose: Channel sequencing and successive approximation control of an 8-bit converter
// Assumes: Comparator answer compHigh is valid while its tap is presented
// Notes:   Result register is cleared by reset only for tidiness; software must not rely on it
`timescale 1ns/1ps
`include "sac_map.svh"
module sac_sequencer #(
  parameter logic [15:0] FAST_CONV_CLK  = `SAC_FAST_CONV_CLK,
  parameter logic [15:0] FAST_BIT_CLK   = `SAC_FAST_BIT_CLK,
  parameter logic [15:0] SLOW_CONV_CLK  = `SAC_SLOW_CONV_CLK,
  parameter logic [15:0] SLOW_BIT_CLK   = `SAC_SLOW_BIT_CLK,
  parameter logic [15:0] SCAN_DELAY_CLK = `SAC_SCAN_DELAY_CLK
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [19:0] cpuAddr,
  input  wire logic        cpuWrEn,
  input  wire logic [7:0]  cpuWrData,
  input  wire logic        cpuBitWrEn,
  input  wire logic [2:0]  cpuBitSel,
  input  wire logic        cpuBitVal,
  input  wire logic        cpuRdEn,
  output logic      [7:0]  cpuRdData,
  input  wire logic        triggerPin,
  input  wire logic [1:0]  edgeMode,
  input  wire logic        haltMode,
  input  wire logic        compHigh,
  output logic      [2:0]  analogSelect,
  output logic             sampleEn,
  output logic      [7:0]  tapSelect,
  output logic             compPowerDown,
  output logic             conversionDoneIrq,
  output logic             triggerIrq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sac_pkg::sac_seq_s st_r;
  sac_pkg::sac_seq_s st_nxt;
  logic              trigPulse;
  logic              modeHit;
  logic              modeWr;
  logic [7:0]        newMode;
  logic              runOn;
  logic              trigOn;
  logic              singleOn;
  logic              fastOn;
  logic              delayScan;
  logic [2:0]        code;
  logic [15:0]       bitLen;
  logic [15:0]       sampleLen;
  logic [2:0]        firstChan;
  logic [2:0]        nextChan;
  logic [7:0]        decided;

  // ----------------------------------------------------------------
  // Trigger pin edge detection
  // ----------------------------------------------------------------
  sac_edge_detect u_edge (
    .clk        (clk),
    .arst_n     (arst_n),
    .triggerPin (triggerPin),
    .edgeMode   (edgeMode),
    .edgePulse  (trigPulse)
  );

  // External interrupt request follows every valid edge, whatever the trigger enable
  assign triggerIrq = trigPulse;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign modeHit   = (cpuAddr == `SAC_ADDR_MODE);
  assign modeWr    = modeHit && (cpuWrEn || cpuBitWrEn);

  always_comb begin
    newMode = cpuWrData;
    if (!cpuWrEn) begin
      newMode            = st_r.mode;
      newMode[cpuBitSel] = cpuBitVal;
    end
  end

  assign runOn     = st_r.mode[`SAC_BIT_RUN];
  assign trigOn    = st_r.mode[`SAC_BIT_TRIG];
  assign singleOn  = st_r.mode[`SAC_BIT_SINGLE];
  assign fastOn    = st_r.mode[`SAC_BIT_FAST];
  // The prohibited single-with-delay code behaves as plain single mode
  assign delayScan = st_r.mode[`SAC_BIT_DELAY] && !singleOn;
  assign code      = st_r.mode[`SAC_CODE_MSB:`SAC_CODE_LSB];

  // Sampling takes what is left of the conversion after eight bit periods
  assign bitLen    = fastOn ? FAST_BIT_CLK : SLOW_BIT_CLK;
  assign sampleLen = fastOn ? FAST_CONV_CLK - (FAST_BIT_CLK << 3)
                            : SLOW_CONV_CLK - (SLOW_BIT_CLK << 3);

  assign firstChan = singleOn ? code : 3'h0;
  assign nextChan  = singleOn ? code :
                     (st_r.chan == code) ? 3'h0 : st_r.chan + 3'h1;

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt         = st_r;
    st_nxt.doneIrq = 1'b0;
    decided        = st_r.approx;
    if (!compHigh) begin
      decided[st_r.bitIdx] = 1'b0;
    end

    if (cpuRdEn) begin
      if (modeHit) begin
        st_nxt.rdData = st_r.mode;
      end else if (cpuAddr == `SAC_ADDR_RESULT) begin
        st_nxt.rdData = st_r.result;
      end else begin
        st_nxt.rdData = 8'h00;
      end
    end

    if (modeWr) begin
      // Any write drops the running conversion; with run set the idle state restarts it or waits for a trigger
      st_nxt.mode  = newMode;
      st_nxt.state = sac_pkg::SAC_ST_IDLE;
      st_nxt.cnt   = 16'h0000;
    end else if (!runOn || haltMode) begin
      st_nxt.state = sac_pkg::SAC_ST_IDLE;
      st_nxt.cnt   = 16'h0000;
    end else if (trigOn && trigPulse && st_r.state != sac_pkg::SAC_ST_IDLE) begin
      st_nxt.state  = sac_pkg::SAC_ST_SAMPLE;
      st_nxt.cnt    = 16'h0000;
      st_nxt.chan   = firstChan;
      st_nxt.approx = 8'h00;
    end else begin
      case (st_r.state)
        sac_pkg::SAC_ST_IDLE: begin
          if (trigOn) begin
            st_nxt.state = sac_pkg::SAC_ST_WAIT;
          end else begin
            st_nxt.state  = sac_pkg::SAC_ST_SAMPLE;
            st_nxt.cnt    = 16'h0000;
            st_nxt.chan   = firstChan;
            st_nxt.approx = 8'h00;
          end
        end
        sac_pkg::SAC_ST_WAIT: begin
          st_nxt.state = sac_pkg::SAC_ST_WAIT;
        end
        sac_pkg::SAC_ST_SAMPLE: begin
          if (st_r.cnt == sampleLen - 16'h0001) begin
            st_nxt.state  = sac_pkg::SAC_ST_COMPARE;
            st_nxt.cnt    = 16'h0000;
            st_nxt.approx = 8'h80;
            st_nxt.bitIdx = 3'h7;
          end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
          end
        end
        sac_pkg::SAC_ST_COMPARE: begin
          if (st_r.cnt == bitLen - 16'h0001) begin
            st_nxt.cnt = 16'h0000;
            if (st_r.bitIdx == 3'h0) begin
              st_nxt.approx  = decided;
              st_nxt.result  = decided;
              st_nxt.doneIrq = 1'b1;
              st_nxt.chan    = nextChan;
              st_nxt.state   = delayScan ? sac_pkg::SAC_ST_DELAY
                                         : sac_pkg::SAC_ST_SAMPLE;
            end else begin
              st_nxt.approx = decided | (8'h01 << (st_r.bitIdx - 3'h1));
              st_nxt.bitIdx = st_r.bitIdx - 3'h1;
            end
          end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
          end
        end
        sac_pkg::SAC_ST_DELAY: begin
          if (st_r.cnt == SCAN_DELAY_CLK - 16'h0001) begin
            st_nxt.state = sac_pkg::SAC_ST_SAMPLE;
            st_nxt.cnt   = 16'h0000;
          end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
          end
        end
        default: begin
          st_nxt.state = sac_pkg::SAC_ST_IDLE;
          st_nxt.cnt   = 16'h0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r       <= '0;
      st_r.mode  <= `SAC_MODE_RESET;
      st_r.state <= sac_pkg::SAC_ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cpuRdData         = st_r.rdData;
  assign analogSelect      = st_r.chan;
  // Hold is kept through compare and delay so the tap sees a stable sample
  assign sampleEn          = (st_r.state == sac_pkg::SAC_ST_SAMPLE);
  assign tapSelect         = st_r.approx;
  // Halt does not touch the run bit, so the comparator stays powered
  assign compPowerDown     = !runOn;
  assign conversionDoneIrq = st_r.doneIrq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] convAge;
  logic        lastDecide;

  assign lastDecide = (st_r.state == sac_pkg::SAC_ST_COMPARE) && (st_r.bitIdx == 3'h0)
                      && (st_r.cnt == bitLen - 16'h0001);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      convAge <= 16'h0000;
    // A trigger restart during sampling re-enters sampling from sampling, so entry is seen by the zero count
    end else if (st_nxt.state == sac_pkg::SAC_ST_SAMPLE && st_nxt.cnt == 16'h0000) begin
      convAge <= 16'h0000;
    end else begin
      convAge <= convAge + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_msb_first;
    (st_r.state == sac_pkg::SAC_ST_SAMPLE) ##1 (st_r.state == sac_pkg::SAC_ST_COMPARE)
      |-> (st_r.approx == 8'h80) && (st_r.bitIdx == 3'h7);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("First trial is not the MSB");

  property p_done_copy;
    conversionDoneIrq |-> $past(lastDecide) && (st_r.result == tapSelect);
  endproperty
  a_done_copy: assert property (p_done_copy)
    else $error("Result not copied at completion");

  property p_result_hold;
    !conversionDoneIrq |-> $stable(st_r.result);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("Result changed without done");

  property p_abort;
    $fell(runOn) |-> (st_r.state == sac_pkg::SAC_ST_IDLE) && !conversionDoneIrq
      ##1 !conversionDoneIrq;
  endproperty
  a_abort: assert property (p_abort)
    else $error("Run clear did not abort");

  property p_power;
    compPowerDown |-> st_r.state == sac_pkg::SAC_ST_IDLE;
  endproperty
  a_power: assert property (p_power)
    else $error("Converting while powered down");

  property p_halt;
    (haltMode && runOn && !modeWr) |=> (st_r.state == sac_pkg::SAC_ST_IDLE) && !compPowerDown;
  endproperty
  a_halt: assert property (p_halt)
    else $error("Halt handling wrong");

  property p_write_reinit;
    modeWr |=> (st_r.state == sac_pkg::SAC_ST_IDLE) && (st_r.mode == $past(newMode));
  endproperty
  a_write_reinit: assert property (p_write_reinit)
    else $error("Mode write did not reinit");

  property p_trig_restart;
    (trigOn && runOn && trigPulse && !modeWr && !haltMode
      && st_r.state != sac_pkg::SAC_ST_IDLE)
      |=> (st_r.state == sac_pkg::SAC_ST_SAMPLE) && (st_r.cnt == 16'h0000)
          && (st_r.chan == firstChan);
  endproperty
  a_trig_restart: assert property (p_trig_restart)
    else $error("Trigger did not restart");

  property p_no_wait;
    !trigOn |-> st_r.state != sac_pkg::SAC_ST_WAIT;
  endproperty
  a_no_wait: assert property (p_no_wait)
    else $error("Waiting for trigger while disabled");

  property p_single_chan;
    (singleOn && st_r.state == sac_pkg::SAC_ST_COMPARE) |-> analogSelect == code;
  endproperty
  a_single_chan: assert property (p_single_chan)
    else $error("Single channel wrong");

  property p_scan_range;
    (!singleOn && st_r.state == sac_pkg::SAC_ST_COMPARE) |-> analogSelect <= code;
  endproperty
  a_scan_range: assert property (p_scan_range)
    else $error("Scan channel out of range");

  property p_conv_time;
    lastDecide && (st_r.state != sac_pkg::SAC_ST_IDLE)
      |-> convAge == (fastOn ? FAST_CONV_CLK : SLOW_CONV_CLK) - 16'h0001;
  endproperty
  a_conv_time: assert property (p_conv_time)
    else $error("Conversion length wrong");

  // Tap holds within each bit period and the routed channel holds throughout compare
  property p_tap_hold;
    (st_r.state == sac_pkg::SAC_ST_COMPARE) && (st_r.cnt != 16'h0000) |-> $stable(tapSelect);
  endproperty
  a_tap_hold: assert property (p_tap_hold)
    else $error("Tap moved inside a bit period");

  property p_chan_hold;
    (st_r.state == sac_pkg::SAC_ST_COMPARE) |-> $stable(analogSelect);
  endproperty
  a_chan_hold: assert property (p_chan_hold)
    else $error("Channel moved during compare");

  property p_wait_hold;
    (st_r.state == sac_pkg::SAC_ST_WAIT) && !trigPulse && !modeWr && runOn && !haltMode
      |=> st_r.state == sac_pkg::SAC_ST_WAIT;
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("Left trigger wait without an edge");

  property p_done_pulse;
    conversionDoneIrq |=> !conversionDoneIrq;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("Completion request longer than one cycle");

  property p_scan_wrap;
    conversionDoneIrq && !singleOn && ($past(st_r.chan) == code) |-> analogSelect == 3'h0;
  endproperty
  a_scan_wrap: assert property (p_scan_wrap)
    else $error("Scan did not wrap to channel 0");

  c_done: cover property (conversionDoneIrq);
  c_scan_wrap: cover property (conversionDoneIrq && !singleOn && code != 3'h0
                               && analogSelect == 3'h0);
  c_trig: cover property (trigOn && trigPulse && st_r.state == sac_pkg::SAC_ST_COMPARE);
  c_abort: cover property ($fell(runOn) && $past(st_r.state) == sac_pkg::SAC_ST_COMPARE);

endmodule // sac_sequencer

/* test_sar_adc_sequencer.sv */
// Purpose: Self-checking bench for the converter sequencer
// Assumes: Analog side comes from sac_analog_model
// Notes:   Inputs change on the falling clock edge
`timescale 1ns/1ps
`include "sac_map.svh"
module test_sar_adc_sequencer;
  // ----------------------------------------------------------------
  // Wiring
  // ----------------------------------------------------------------
  localparam int LIMIT = 20000;
  localparam logic [63:0] LEVELS = 64'hC301_7F80_A55A_FF00;
  typedef struct {logic [7:0] mode; logic [2:0] ch; int per;} sac_row_s;
  logic        clk;
  logic        arst_n;
  logic [19:0] cpuAddr;
  logic        cpuWrEn;
  logic [7:0]  cpuWrData;
  logic        cpuBitWrEn;
  logic [2:0]  cpuBitSel;
  logic        cpuBitVal;
  logic        cpuRdEn;
  logic [7:0]  cpuRdData;
  logic        triggerPin;
  logic [1:0]  edgeMode;
  logic        haltMode;
  logic        compHigh;
  logic [2:0]  analogSelect;
  logic        sampleEn;
  logic [7:0]  tapSelect;
  logic        compPowerDown;
  logic        conversionDoneIrq;
  logic        triggerIrq;
  int          failures = 0;
  int          checks = 0;
  int          cycles = 0;
  sac_row_s    rows [9];

  sac_sequencer u_dut (.clk(clk), .arst_n(arst_n), .cpuAddr(cpuAddr), .cpuWrEn(cpuWrEn),
    .cpuWrData(cpuWrData), .cpuBitWrEn(cpuBitWrEn), .cpuBitSel(cpuBitSel),
    .cpuBitVal(cpuBitVal), .cpuRdEn(cpuRdEn), .cpuRdData(cpuRdData),
    .triggerPin(triggerPin), .edgeMode(edgeMode), .haltMode(haltMode), .compHigh(compHigh),
    .analogSelect(analogSelect), .sampleEn(sampleEn), .tapSelect(tapSelect),
    .compPowerDown(compPowerDown), .conversionDoneIrq(conversionDoneIrq),
    .triggerIrq(triggerIrq));

  sac_analog_model u_analog (.clk(clk), .levels(LEVELS), .analogSelect(analogSelect),
    .sampleEn(sampleEn), .tapSelect(tapSelect), .compPowerDown(compPowerDown),
    .compHigh(compHigh));

  always #4 clk = ~clk;

  // A hang counts as a mismatch and still reaches the verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] lvl(input int ch);
    return LEVELS[8*ch +: 8];
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [19:0] addr, input logic [7:0] data);
    @(negedge clk);
    cpuAddr = addr;
    cpuWrData = data;
    cpuWrEn = 1'b1;
    @(negedge clk);
    cpuWrEn = 1'b0;
  endtask

  task automatic bitwr(input logic [2:0] sel, input logic val);
    @(negedge clk);
    cpuAddr = `SAC_ADDR_MODE;
    cpuBitSel = sel;
    cpuBitVal = val;
    cpuBitWrEn = 1'b1;
    @(negedge clk);
    cpuBitWrEn = 1'b0;
  endtask

  task automatic rd(input logic [19:0] addr, input logic [7:0] exp);
    @(negedge clk);
    cpuAddr = addr;
    cpuRdEn = 1'b1;
    @(negedge clk);
    cpuRdEn = 1'b0;
    chk(cpuRdData, exp);
  endtask

  // Returns cycles until the next done pulse, or 0 if none came within lim
  task automatic waitDone(input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (conversionDoneIrq !== 1'b1 && n < lim);
    if (conversionDoneIrq !== 1'b1) n = 0;
  endtask

  task automatic trig(input logic v, input logic e);
    @(negedge clk);
    triggerPin = v;
    @(negedge clk);
    chk(triggerIrq, e);
    @(negedge clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    int em;
    clk = 0; arst_n = 0; cpuAddr = 0; cpuWrEn = 0; cpuWrData = 0; cpuBitWrEn = 0;
    cpuBitSel = 0; cpuBitVal = 0; cpuRdEn = 0; triggerPin = 0; edgeMode = 2'h1; haltMode = 0;
    for (int i = 0; i < 8; i++) rows[i] = '{8'(8'h91 | (i << 1)), 3'(i), 120};
    rows[8] = '{8'h87, 3'h3, 242};
    repeat (20) @(negedge clk);
    arst_n = 1;
    @(negedge clk);
    chk(compPowerDown, 1'b1);
    chk(conversionDoneIrq, 1'b0);
    rd(`SAC_ADDR_MODE, 8'h00);
    rd(20'h0_FF00, 8'h00);
    for (int i = 0; i < 9; i++) begin
      wr(`SAC_ADDR_MODE, rows[i].mode);
      waitDone(400, n);
      chk(n != 0, 1'b1);
      waitDone(400, n);
      chk(16'(n), 16'(rows[i].per));
      chk(analogSelect, rows[i].ch);
      chk(tapSelect, lvl(rows[i].ch));
      chk(sampleEn, 1'b1);
      rd(`SAC_ADDR_RESULT, lvl(rows[i].ch));
    end
    // Scan wraps after the last channel of the range
    wr(`SAC_ADDR_MODE, 8'h94);
    for (int i = 0; i < 4; i++) begin
      waitDone(300, n);
      rd(`SAC_ADDR_RESULT, lvl(i % 3));
    end
    wr(`SAC_ADDR_MODE, 8'hB4);
    waitDone(300, n);
    waitDone(300, n);
    chk(16'(n), 16'd136);
    chk(sampleEn, 1'b0);
    // Abort by single-bit clear in mid conversion
    wr(`SAC_ADDR_MODE, 8'h96);
    waitDone(300, n);
    repeat (50) @(negedge clk);
    bitwr(3'h7, 1'b0);
    waitDone(300, n);
    chk(16'(n), 16'd0);
    chk(compPowerDown, 1'b1);
    rd(`SAC_ADDR_RESULT, lvl(0));
    rd(`SAC_ADDR_MODE, 8'h16);
    wr(`SAC_ADDR_RESULT, 8'hFF);
    rd(`SAC_ADDR_RESULT, lvl(0));
    bitwr(3'h7, 1'b1);
    waitDone(200, n);
    chk(n != 0, 1'b1);
    // Mode write in mid conversion starts over
    repeat (60) @(negedge clk);
    wr(`SAC_ADDR_MODE, 8'h96);
    waitDone(300, n);
    chk(n >= 110 && n <= 130, 1'b1);
    // Halt stops conversion but keeps the comparator powered
    haltMode = 1'b1;
    waitDone(300, n);
    chk(16'(n), 16'd0);
    chk(compPowerDown, 1'b0);
    haltMode = 1'b0;
    waitDone(200, n);
    chk(n != 0, 1'b1);
    // Trigger pin ignored while external trigger is disabled
    triggerPin = 1'b1;
    waitDone(300, n);
    chk(16'(n), 16'd120);
    triggerPin = 1'b0;
    // External trigger: wait for an edge, every valid edge raises the interrupt
    wr(`SAC_ADDR_MODE, 8'hD6);
    waitDone(250, n);
    chk(16'(n), 16'd0);
    for (em = 0; em < 4; em++) begin
      edgeMode = 2'(em);
      trig(1'b1, em == 1 || em == 2);
      trig(1'b0, em == 0 || em == 2);
    end
    waitDone(140, n);
    chk(n != 0, 1'b1);
    rd(`SAC_ADDR_RESULT, lvl(0));
    // Second reset in mid run
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(compPowerDown, 1'b1);
    arst_n = 1'b1;
    rd(`SAC_ADDR_MODE, 8'h00);
    print_verdict();
  end
endmodule // test_sar_adc_sequencer
